// ---- sblc_params.svh ----
// constants for the software backed line cache
`ifndef SBLC_PARAMS_SVH
`define SBLC_PARAMS_SVH
`define SBLC_LINES        8
`define SBLC_LINE_BYTES   32
`define SBLC_OFS_BITS     5
`define SBLC_SWM_BASE     32'h40000000
`define SBLC_SWM_SIZE     32'h40000000
`define SBLC_MEM_BASE     32'h10000000
`define SBLC_MEM_SIZE     32'h10000000
`endif

// ---- sblc_pkg.sv ----
// types shared by the software backed line cache
`include "sblc_params.svh"
package sblc_pkg;
  typedef enum logic [2:0] {
    SBLC_OP_READ  = 3'h0,
    SBLC_OP_WRITE = 3'h1,
    SBLC_OP_PREF  = 3'h2,
    SBLC_OP_INV   = 3'h3,
    SBLC_OP_FLUSH = 3'h4
  } sblc_op_t;

  typedef struct packed {
    sblc_op_t    op;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } sblc_req_t;

  typedef struct packed {
    logic [31:0]  addr;
    logic [31:0]  mask;
    logic [255:0] data;
  } sblc_evict_t;

  typedef enum logic [2:0] {
    SBLC_IDLE  = 3'h0,
    SBLC_EVICT = 3'h1,
    SBLC_FILL  = 3'h2,
    SBLC_FLUSH = 3'h3,
    SBLC_DONE  = 3'h4
  } sblc_state_t;
endpackage : sblc_pkg

// ---- sblc_cache.sv ----
// software backed line cache: eight slot fully associative, write-back
`timescale 1ns/1ps
`include "sblc_params.svh"
module sblc_cache #(
  parameter int LINES      = `SBLC_LINES,      // line slots
  parameter int LINE_BYTES = `SBLC_LINE_BYTES  // bytes per line
) (
  input  wire logic                 MCLK,       // tile clock, 100 MHz
  input  wire logic                 SYS_RST,    // sync reset, active high
  input  wire logic                 CE,         // clock enable
  input  wire logic                 SWM_ENABLE, // software region enable
  input  wire logic                 REQ_VALID,  // processor request
  input  wire sblc_pkg::sblc_req_t  REQ,        // request payload
  output logic                      REQ_READY,  // request accepted
  output logic                      RSP_VALID,  // read data / done pulse
  output logic [31:0]               RSP_DATA,   // read word
  output logic                      TRAP,       // access trap pulse
  output logic                      FILL_REQ,   // fill request level
  output logic [31:0]               FILL_ADDR,  // aligned fill address
  input  wire logic                 FILL_VALID, // fill line delivered
  input  wire logic [255:0]         FILL_DATA,  // fill line
  output logic                      EVICT_REQ,  // eviction request level
  output sblc_pkg::sblc_evict_t     EVICT,      // eviction line
  input  wire logic                 EVICT_ACK   // handler has read line
);
  import sblc_pkg::*;

  localparam int N = LINES;
  localparam int OB = `SBLC_OFS_BITS;
  localparam int TB = 32 - OB;
  // tree replacement and 3-bit slot indices are built for eight lines
  if (LINES != 8 || LINE_BYTES != 32) begin : g_size_check
    $error("sblc_cache serves only eight lines of 32 bytes");
  end

  // ---------------------------------------------------------------
  // line store
  // ---------------------------------------------------------------
  logic [TB-1:0]  tag      [N];
  logic [255:0]   data     [N];
  logic [31:0]    dmask    [N];
  logic [N-1:0]   valid, dirty;
  logic [6:0]     plru;            // tree bits, node 0 is root
  sblc_state_t    state;
  sblc_req_t      cur;
  logic [2:0]     slot, fl_idx;

  logic [TB-1:0]  next_tag   [N];
  logic [255:0]   next_data  [N];
  logic [31:0]    next_dmask [N];
  logic [N-1:0]   next_valid, next_dirty;
  logic [6:0]     next_plru;
  sblc_state_t    next_state;
  sblc_req_t      next_cur;
  logic [2:0]     next_slot, next_fl_idx;
  logic           next_rsp_valid, next_trap;
  logic [31:0]    next_rsp_data;

  // lookup over all slots, no index bits: any line in any slot
  logic           hit, full;
  logic [2:0]     hit_idx, free_idx, plru_idx, victim;
  logic           in_swm, in_mem, mapped;
  always_comb begin
    hit = 1'b0;
    hit_idx = 3'h0;
    free_idx = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (valid[i] && tag[i] == REQ.addr[31:OB]) begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
      if (!valid[i])
        free_idx = 3'(i);
    end
    full = &valid;
    // walk the tree away from the most recently used side
    plru_idx[2] = plru[0];
    plru_idx[1] = plru[1 + plru_idx[2]];
    plru_idx[0] = plru[3 + {plru_idx[2], plru_idx[1]}];
    victim = full ? plru_idx : free_idx;
    in_swm = (REQ.addr - `SBLC_SWM_BASE) < `SBLC_SWM_SIZE;
    in_mem = (REQ.addr - `SBLC_MEM_BASE) < `SBLC_MEM_SIZE;
    mapped = in_mem || (in_swm && SWM_ENABLE);
  end

  // point tree bits away from a touched slot
  function automatic logic [6:0] touch(logic [6:0] t, logic [2:0] s);
    logic [6:0] r;
    r = t;
    r[0] = !s[2];
    r[1 + s[2]] = !s[1];
    r[3 + {s[2], s[1]}] = !s[0];
    return r;
  endfunction : touch

  // ---------------------------------------------------------------
  // control and next state
  // ---------------------------------------------------------------
  logic idle_take;
  assign idle_take = (state == SBLC_IDLE) && REQ_VALID;
  // a trapped access is refused, not taken; frozen cycles take nothing
  assign REQ_READY = idle_take && CE &&
                     (REQ.op == SBLC_OP_INV || REQ.op == SBLC_OP_FLUSH ||
                      (mapped && hit));

  always_comb begin
    next_tag = tag;
    next_data = data;
    next_dmask = dmask;
    next_valid = valid;
    next_dirty = dirty;
    next_plru = plru;
    next_state = state;
    next_cur = cur;
    next_slot = slot;
    next_fl_idx = fl_idx;
    next_rsp_valid = 1'b0;
    next_rsp_data = RSP_DATA;
    next_trap = 1'b0;
    case (state)
      SBLC_IDLE: begin
        if (REQ_VALID) begin
          next_cur = REQ;
          if (REQ.op == SBLC_OP_INV) begin
            // drop every line, dirty or not, with no eviction
            next_valid = '0;
            next_dirty = '0;
            next_rsp_valid = 1'b1;
          end else if (REQ.op == SBLC_OP_FLUSH) begin
            next_fl_idx = 3'h0;
            next_state = SBLC_FLUSH;
          end else if (!mapped) begin
            next_trap = 1'b1;
          end else if (hit) begin
            next_plru = touch(plru, hit_idx);
            next_rsp_valid = 1'b1;
            next_rsp_data = data[hit_idx][{REQ.addr[4:2], 5'h00} +: 32];
            if (REQ.op == SBLC_OP_WRITE) begin
              for (int b = 0; b < 4; b++) begin
                if (REQ.be[b]) begin
                  // cached copy only, backing store untouched
                  next_data[hit_idx][{REQ.addr[4:2], 2'(b), 3'h0} +: 8] =
                    REQ.wdata[8*b +: 8];
                  next_dmask[hit_idx][{REQ.addr[4:2], 2'(b)}] = 1'b1;
                end
              end
              next_dirty[hit_idx] = 1'b1;
            end
          end else begin
            // miss: stall the request and allocate a slot
            next_slot = victim;
            next_state = (full && dirty[victim]) ? SBLC_EVICT
                                                 : SBLC_FILL;
          end
        end
      end
      SBLC_EVICT: begin
        if (EVICT_ACK) begin
          next_valid[slot] = 1'b0;
          next_dirty[slot] = 1'b0;
          next_dmask[slot] = '0;
          next_state = (cur.op == SBLC_OP_FLUSH) ? SBLC_FLUSH : SBLC_FILL;
        end
      end
      SBLC_FILL: begin
        if (FILL_VALID) begin
          next_tag[slot] = cur.addr[31:OB];
          next_data[slot] = FILL_DATA;
          next_dmask[slot] = '0;
          next_valid[slot] = 1'b1;
          next_dirty[slot] = 1'b0;
          next_plru = touch(plru, slot);
          next_state = SBLC_DONE;
        end
      end
      SBLC_FLUSH: begin
        // scan slots; dirty ones go out through the eviction path
        if (valid[fl_idx] && dirty[fl_idx]) begin
          next_slot = fl_idx;
          next_state = SBLC_EVICT;
        end else if (fl_idx == 3'(N - 1)) begin
          next_rsp_valid = 1'b1;
          next_state = SBLC_IDLE;
        end else begin
          next_fl_idx = fl_idx + 3'h1;
        end
      end
      SBLC_DONE: begin
        // retry finds the new line as a hit; keeps one write path
        next_state = SBLC_IDLE;
      end
      default: next_state = SBLC_IDLE;
    endcase
  end

  // fill and eviction requests present line-aligned address
  assign FILL_REQ  = (state == SBLC_FILL);
  assign FILL_ADDR = {cur.addr[31:OB], {OB{1'b0}}};
  assign EVICT_REQ = (state == SBLC_EVICT);
  // one driver for the whole line record the handler reads
  assign EVICT = '{addr: {tag[slot], {OB{1'b0}}},
                   mask: dmask[slot],
                   data: data[slot]};

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      valid <= '0;
      dirty <= '0;
      plru <= '0;
      state <= SBLC_IDLE;
      cur <= '0;
      slot <= 3'h0;
      fl_idx <= 3'h0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 32'h0;
      TRAP <= 1'b0;
    end else if (CE) begin
      tag <= next_tag;
      data <= next_data;
      dmask <= next_dmask;
      valid <= next_valid;
      dirty <= next_dirty;
      plru <= next_plru;
      state <= next_state;
      cur <= next_cur;
      slot <= next_slot;
      fl_idx <= next_fl_idx;
      RSP_VALID <= next_rsp_valid;
      RSP_DATA <= next_rsp_data;
      TRAP <= next_trap;
    end
  end
endmodule : sblc_cache

// ---- sblc_cache_properties.sv ----
// checker for the line cache port handshakes
`timescale 1ns/1ps
module sblc_chk (
  input wire logic                  MCLK,       // clock
  input wire logic                  SYS_RST,    // reset
  input wire logic                  CE,         // run
  input wire logic                  SWM_ENABLE, // region on
  input wire logic                  REQ_VALID,  // request
  input wire sblc_pkg::sblc_req_t   REQ,        // payload
  input wire logic                  REQ_READY,  // taken
  input wire logic                  RSP_VALID,  // answer
  input wire logic [31:0]           RSP_DATA,   // word
  input wire logic                  TRAP,       // trap
  input wire logic                  FILL_REQ,   // fill
  input wire logic [31:0]           FILL_ADDR,  // fill line
  input wire logic                  FILL_VALID, // line in
  input wire logic [255:0]          FILL_DATA,  // line
  input wire logic                  EVICT_REQ,  // evict
  input wire sblc_pkg::sblc_evict_t EVICT,      // line out
  input wire logic                  EVICT_ACK   // taken
);
  import sblc_pkg::*;
  logic sw;
  // region decode; frozen cycles are skipped as no state moves then
  assign sw = REQ.addr[31:30] == 2'b01;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST || !CE);
  a_trap_off: assert property (
    REQ_VALID && sw && !SWM_ENABLE && !FILL_REQ && !EVICT_REQ
    |-> !REQ_READY ##1 !FILL_REQ) else $error("fill from region off");
  a_trap_cause: assert property (
    TRAP |-> $past(REQ_VALID) && !$past(REQ_READY)) else $error("bad trap");
  a_fill_hold: assert property (FILL_REQ && !FILL_VALID |=>
    FILL_REQ && $stable(FILL_ADDR) && FILL_ADDR[4:0] == 5'h00)
    else $error("fill request moved");
  a_evict_hold: assert property (EVICT_REQ && !EVICT_ACK |=>
    EVICT_REQ && $stable(EVICT)) else $error("eviction moved");
  a_evict_line: assert property (EVICT_REQ |-> !FILL_REQ &&
    EVICT.mask != 32'h0 && EVICT.addr[4:0] == 5'h00) else $error("bad evict");
  a_stall_busy: assert property (
    FILL_REQ || EVICT_REQ |-> !REQ_READY) else $error("taken while busy");
  a_fill_retry: assert property (FILL_REQ && FILL_VALID && REQ_VALID
    |=> !FILL_REQ ##1 REQ_READY) else $error("no hit after fill");
  a_hit_answer: assert property (
    REQ_VALID && REQ_READY && REQ.op != SBLC_OP_FLUSH |=> RSP_VALID)
    else $error("no answer");
  a_inv_quiet: assert property (
    REQ_VALID && REQ_READY && REQ.op == SBLC_OP_INV |=> !EVICT_REQ [*3])
    else $error("evict on invalidate");
  c_fill: cover property (FILL_REQ && FILL_VALID);
  c_evict: cover property (EVICT_REQ && EVICT_ACK);
  c_trap: cover property (TRAP);
endmodule : sblc_chk
bind sblc_cache sblc_chk chk (.MCLK, .SYS_RST, .CE, .SWM_ENABLE, .REQ_VALID,
  .REQ, .REQ_READY, .RSP_VALID, .RSP_DATA, .TRAP, .FILL_REQ, .FILL_ADDR,
  .FILL_VALID, .FILL_DATA, .EVICT_REQ, .EVICT, .EVICT_ACK);

// ---- sblc_handler.sv ----
// fill and evict handler cores seen from the cache
`timescale 1ns/1ps
module sblc_handler (
  input  wire logic        clk,        // tile clock
  input  wire logic [3:0]  lat,        // answer delay
  input  wire logic        fill_req,   // line wanted
  input  wire logic [31:0] fill_addr,  // line address
  output logic             fill_valid, // line given
  output logic [255:0]     fill_data,  // word w holds addr + 4w
  input  wire logic        evict_req,  // line offered
  output logic             evict_ack   // line taken
);
  int wait_n;
  initial begin
    fill_valid = 1'b0;
    evict_ack  = 1'b0;
    fill_data  = '1;
    wait_n     = 0;
  end
  // one answer at a time after lat idle cycles; idle data toggles
  always @(negedge clk) begin
    fill_valid <= 1'b0;
    evict_ack  <= 1'b0;
    fill_data  <= ~fill_data;
    if ((fill_req || evict_req) && !fill_valid && !evict_ack) begin
      wait_n <= (wait_n < lat) ? wait_n + 1 : 0;
      if (wait_n >= lat && evict_req)
        evict_ack <= 1'b1;
      else if (wait_n >= lat) begin
        fill_valid <= 1'b1;
        for (int w = 0; w < 8; w++)
          fill_data[32*w+:32] <= fill_addr + 32'(4 * w);
      end
    end
  end
endmodule : sblc_handler

// ---- tb.sv ----
// self-checking bench for the software backed line cache
`timescale 1ns/1ps
module tb;
  import sblc_pkg::*;
  logic         MCLK, SYS_RST, CE, SWM_ENABLE, REQ_VALID, REQ_READY, tr;
  logic         RSP_VALID, TRAP, FILL_REQ, FILL_VALID, EVICT_REQ, EVICT_ACK;
  logic [31:0]  RSP_DATA, FILL_ADDR, rd, fills, ev_cnt, f0;
  logic [255:0] FILL_DATA;
  logic [3:0]   lat;
  sblc_req_t    REQ;
  sblc_evict_t  EVICT, last_ev;
  int           fails, cmp_count;
  sblc_cache dut (.MCLK, .SYS_RST, .CE, .SWM_ENABLE, .REQ_VALID, .REQ,
    .REQ_READY, .RSP_VALID, .RSP_DATA, .TRAP, .FILL_REQ, .FILL_ADDR,
    .FILL_VALID, .FILL_DATA, .EVICT_REQ, .EVICT, .EVICT_ACK);
  sblc_handler hnd (.clk(MCLK), .lat, .fill_req(FILL_REQ),
    .fill_addr(FILL_ADDR), .fill_valid(FILL_VALID), .fill_data(FILL_DATA),
    .evict_req(EVICT_REQ), .evict_ack(EVICT_ACK));
  // tally lines moved and keep the last line handed out
  always @(posedge MCLK) begin
    fills <= fills + 32'(FILL_REQ && FILL_VALID);
    if (EVICT_REQ && EVICT_ACK) begin
      ev_cnt  <= ev_cnt + 32'h1;
      last_ev <= EVICT;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // same offset, stride 4 KiB, odd k in the software region
  function automatic logic [31:0] ln(input int k);
    return (k[0] ? 32'h40000000 : 32'h10000000) + 32'(k) * 32'h1000;
  endfunction : ln
  // hold a request until taken or trapped, then wait for its answer
  task automatic acc(input sblc_op_t op, input logic [31:0] a, wd);
    int i;
    REQ = '{op, a, wd, 4'hF};
    REQ_VALID = 1'b1;
    tr = 1'b0;
    for (i = 0; i < 300 && !tr; i++) begin
      #1;
      if (REQ_READY)
        break;
      @(negedge MCLK);
      tr = TRAP;
    end
    if (!tr)
      @(negedge MCLK);
    REQ_VALID = 1'b0;
    while (!tr && !RSP_VALID && i < 300) begin
      @(negedge MCLK);
      i++;
    end
    if (i >= 300) begin
      fails++;
      close_out();
    end
    rd = RSP_DATA;
    @(negedge MCLK);
  endtask : acc
  task automatic t_trap;
    acc(SBLC_OP_READ, 32'h40000040, 32'h0);
    chk("trap off", tr, 1'b1);
    SWM_ENABLE = 1'b1;
    acc(SBLC_OP_READ, 32'h80000000, 32'h0);
    chk("trap hole", tr, 1'b1);
    chk("no fill", fills, 32'h0);
  endtask : t_trap
  // clock enable low: an invalidate is neither taken nor answered
  task automatic t_freeze;
    CE = 1'b0;
    REQ = '{SBLC_OP_INV, 32'h0, 32'h0, 4'hF};
    REQ_VALID = 1'b1;
    repeat (3) @(negedge MCLK);
    chk("frozen ready", REQ_READY, 1'b0);
    chk("frozen answer", RSP_VALID, 1'b0);
    CE = 1'b1;
    #1;
    chk("thawed ready", REQ_READY, 1'b1);
    @(negedge MCLK);
    REQ_VALID = 1'b0;
    chk("thawed answer", RSP_VALID, 1'b1);
    @(negedge MCLK);
  endtask : t_freeze
  // slow handler; top line of the region written, then flushed out
  task automatic t_wback;
    lat = 4'h3;
    acc(SBLC_OP_READ, 32'h7FFFFFE4, 32'h0);
    chk("fill word", rd, 32'h7FFFFFE4);
    acc(SBLC_OP_WRITE, 32'h7FFFFFE4, 32'h1234ABCD);
    acc(SBLC_OP_READ, 32'h7FFFFFE4, 32'h0);
    chk("write kept", rd, 32'h1234ABCD);
    chk("no store", ev_cnt, 32'h0);
    acc(SBLC_OP_FLUSH, 32'h0, 32'h0);
    chk("flush out", ev_cnt, 32'h1);
    chk("ev addr", last_ev.addr, 32'h7FFFFFE0);
    chk("ev mask", last_ev.mask, 32'h000000F0);
    chk("ev word", last_ev.data[63:32], 32'h1234ABCD);
  endtask : t_wback
  // prompt handler; capacity, invalidate, then replacement with a hot line
  task automatic t_cap;
    lat = 4'h0;
    acc(SBLC_OP_INV, 32'h0, 32'h0);
    f0 = fills;
    acc(SBLC_OP_PREF, ln(0), 32'h0);
    for (int k = 0; k < 16; k++) begin
      acc(SBLC_OP_READ, ln(k % 8), 32'h0);
      chk("line word", rd, ln(k % 8));
    end
    chk("eight", fills - f0, 32'h8);
    acc(SBLC_OP_WRITE, ln(2), 32'h5A5A0F0F);
    acc(SBLC_OP_INV, 32'h0, 32'h0);
    acc(SBLC_OP_READ, ln(0), 32'h0);
    chk("inv refill", fills - f0, 32'h9);
    chk("inv quiet", ev_cnt, 32'h1);
    acc(SBLC_OP_WRITE, ln(2), 32'h5A5A0F0F);
    for (int k = 8; k < 24; k++) begin
      acc(SBLC_OP_READ, ln(0), 32'h0);
      acc(SBLC_OP_READ, ln(k), 32'h0);
    end
    chk("hot kept", fills - f0, 32'h1A);
    chk("hot no evict", ev_cnt, 32'h1);
    // eight cold misses walk every leaf, so the dirty line must go out
    for (int k = 24; k < 32; k++)
      acc(SBLC_OP_READ, ln(k), 32'h0);
    chk("dirty once", ev_cnt, 32'h2);
    chk("dirty out", last_ev.addr, ln(2));
    chk("dirty mask", last_ev.mask, 32'h0000000F);
    chk("dirty word", last_ev.data[31:0], 32'h5A5A0F0F);
  endtask : t_cap
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    {SYS_RST, CE, SWM_ENABLE, REQ_VALID, lat} = 8'hC0;
    {REQ, fills, ev_cnt, fails, cmp_count} = '0;
    repeat (6) @(negedge MCLK);
    SYS_RST = 1'b0;
    t_trap();
    t_freeze();
    t_wback();
    t_cap();
    close_out();
  end
endmodule : tb
